// [logic/sac_top.v]
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_top (
  input wire clk,
  input wire rst_b,
  input wire convert_start,
  input wire chip_select_b,
  input wire serial_clock,
  input wire serial_data_in,
  input wire power_down,
  input wire conversion_speed_select,
  input wire busy_enable,
  input wire [1:0] channel_count,
  input wire [15:0] result_in,
  input wire result_valid,
  output reg result_ready,
  output reg [15:0] config_word,
  output reg serial_data_out,
  output reg serial_data_out_oe_b,
  output reg busy_or_second_data_out,
  output reg busy_or_second_data_out_oe_b,
  output reg conversion_done
);
  // ------------------------------------------------------------
  // Derived counts
  // ------------------------------------------------------------
  // Start synchroniser and edge detect eat into the conversion budget,
  // so the counted part is shortened by that latency
  function [`SAC_CNT_W-1:0] sac_conv_cyc;
    input integer ns;
    integer q;
    begin
      q = ns / `SAC_CLK_NS - `SAC_START_LAT;
      sac_conv_cyc = q[`SAC_CNT_W-1:0];
    end
  endfunction
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_READY = 2'h2;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [1:0] cnv_s;
  reg [1:0] cs_s;
  reg [1:0] sck_s;
  reg [1:0] din_s;
  reg [1:0] pd_s;
  reg cnv_d;
  reg sck_d;
  reg cs_d;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnv_s <= 2'h0;
      cs_s <= 2'h3;
      sck_s <= 2'h0;
      din_s <= 2'h0;
      pd_s <= 2'h0;
      cnv_d <= 1'b0;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      cnv_s <= {cnv_s[0], convert_start};
      cs_s <= {cs_s[0], chip_select_b};
      sck_s <= {sck_s[0], serial_clock};
      din_s <= {din_s[0], serial_data_in};
      pd_s <= {pd_s[0], power_down};
      cnv_d <= cnv_s[1];
      sck_d <= sck_s[1];
      cs_d <= cs_s[1] | pd_s[1];
    end
  end
  wire cnv_rise = cnv_s[1] && !cnv_d;
  wire sck_fall = sck_d && !sck_s[1];
  wire off_now = cs_s[1] | pd_s[1];
  wire cs_fall = cs_d && !off_now;

  // ------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------
  reg [1:0] state;
  reg [`SAC_CNT_W-1:0] timer;
  reg [15:0] cfg_shadow;
  reg [`SAC_CNT_W-1:0] conv_cyc;
  // Length latched at start: a mode change mid-conversion is harmless
  reg [`SAC_CNT_W-1:0] conv_len;
  always @* begin
    conv_cyc = sac_conv_cyc(`SAC_CONV_NORM_2CH_NS);
    if (conversion_speed_select == `SAC_SPEED_NORMAL) begin
      case (channel_count)
        `SAC_CH2: conv_cyc = sac_conv_cyc(`SAC_CONV_NORM_2CH_NS);
        `SAC_CH4: conv_cyc = sac_conv_cyc(`SAC_CONV_NORM_4CH_NS);
        `SAC_CH6: conv_cyc = sac_conv_cyc(`SAC_CONV_NORM_6CH_NS);
        default: conv_cyc = sac_conv_cyc(`SAC_CONV_NORM_8CH_NS);
      endcase
    end else begin
      case (channel_count)
        `SAC_CH2: conv_cyc = sac_conv_cyc(`SAC_CONV_FAST_2CH_NS);
        `SAC_CH4: conv_cyc = sac_conv_cyc(`SAC_CONV_FAST_4CH_NS);
        `SAC_CH6: conv_cyc = sac_conv_cyc(`SAC_CONV_FAST_6CH_NS);
        default: conv_cyc = sac_conv_cyc(`SAC_CONV_FAST_8CH_NS);
      endcase
    end
  end

  // Results queue between conversion core and serial port
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  reg fifo_pop;
  wire eoc = (state == ST_CONV) && (timer == conv_len - 1'b1);
  sac_fifo #(.WIDTH(32), .DEPTH(8), .AW(3)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(eoc),
    .in_ready(fifo_in_ready),
    .in_data({result_in, cfg_shadow}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      timer <= {`SAC_CNT_W{1'b0}};
      conv_len <= {`SAC_CNT_W{1'b0}};
      cfg_shadow <= 16'h0000;
      result_ready <= 1'b0;
      conversion_done <= 1'b0;
      busy_or_second_data_out <= 1'b0;
    end else begin
      conversion_done <= 1'b0;
      result_ready <= 1'b0;
      case (state)
        ST_IDLE: begin
          // A full queue drops the start so no result is lost silently
          if (cnv_rise && fifo_in_ready) begin
            state <= ST_CONV;
            timer <= {`SAC_CNT_W{1'b0}};
            conv_len <= conv_cyc;
            cfg_shadow <= config_word;
            busy_or_second_data_out <= busy_enable;
          end
        end
        ST_CONV: begin
          timer <= timer + 1'b1;
          if (eoc) begin
            state <= ST_READY;
            busy_or_second_data_out <= 1'b0;
            conversion_done <= 1'b1;
          end
        end
        ST_READY: begin
          result_ready <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  reg [31:0] shifter;
  reg [5:0] bit_cnt;
  reg [15:0] din_shift;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shifter <= 32'h0000_0000;
      bit_cnt <= 6'h00;
      din_shift <= 16'h0000;
      config_word <= 16'hFFFF;
      fifo_pop <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_out_oe_b <= 1'b1;
      busy_or_second_data_out_oe_b <= 1'b1;
    end else begin
      fifo_pop <= 1'b0;
      busy_or_second_data_out_oe_b <= !busy_enable;
      if (off_now) begin
        serial_data_out_oe_b <= 1'b1;
        bit_cnt <= 6'h00;
      end else if (cs_fall && !fifo_out_valid) begin
        // Select ahead of the result: drive, then load when it lands
        serial_data_out_oe_b <= 1'b0;
      end else if (cs_fall || (bit_cnt == 6'h00 && fifo_out_valid
                   && !fifo_pop && state == ST_IDLE)) begin
        // select held low loads the next queued result once no frame is pending
        shifter <= fifo_out_data;
        serial_data_out <= fifo_out_data[31];
        serial_data_out_oe_b <= 1'b0;
        bit_cnt <= 6'h01;
        fifo_pop <= fifo_out_valid;
      end else if (sck_fall && bit_cnt != 6'h00) begin
        din_shift <= {din_shift[14:0], din_s[1]};
        shifter <= {shifter[30:0], 1'b0};
        serial_data_out <= shifter[30];
        if (bit_cnt == `SAC_WORD_BITS) begin
          config_word <= {din_shift[14:0], din_s[1]};
        end
        if (bit_cnt == `SAC_FRAME_BITS) begin
          bit_cnt <= 6'h00;
        end else begin
          bit_cnt <= bit_cnt + 1'b1;
        end
      end
    end
  end
endmodule

// [logic/sac_regs.vh]
// What this block does
// - Speed select 1 normal default, 0 fast
// - Conversion done within max conversion time, result_ready one cycle later
// - Busy asserts within 520 ns of start
// - Result captured at conversion end, config word latched at conversion start
// - Sixteen falling edges shift out result
// - Next sixteen edges shift out config word
// - Select low drives most significant bit first
// - Select high puts data output high impedance
// - Serial input captured on clock falling edges
// - Output advances only after falling edge
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
`define SAC_CLK_NS 40
`define SAC_BUSY_MAX_NS 520
`define SAC_CONV_FAST_2CH_NS 1630
`define SAC_CONV_FAST_4CH_NS 3340
`define SAC_CONV_FAST_6CH_NS 5000
`define SAC_CONV_FAST_8CH_NS 6700
`define SAC_CONV_NORM_2CH_NS 1720
`define SAC_CONV_NORM_4CH_NS 3430
`define SAC_CONV_NORM_6CH_NS 5090
`define SAC_CONV_NORM_8CH_NS 6790
`define SAC_WORD_BITS 16
`define SAC_FRAME_BITS 32
`define SAC_MSB 15
`define SAC_CNT_W 8
`define SAC_START_LAT 3
`define SAC_CH2 2'h0
`define SAC_CH4 2'h1
`define SAC_CH6 2'h2
`define SAC_CH8 2'h3
`define SAC_SPEED_NORMAL 1'h1
`endif

// [logic/sac_fifo.v]
`timescale 1ns/1ps
module sac_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// [sim/sac_monitor.sv]
`timescale 1ns/1ps
module sac_monitor (
  input logic clk,
  input logic rst_b,
  input logic convert_start,
  input logic chip_select_b,
  input logic serial_clock,
  input logic serial_data_in,
  input logic power_down,
  input logic conversion_speed_select,
  input logic busy_enable,
  input logic result_valid,
  input logic result_ready,
  input logic conversion_done,
  input logic [1:0] channel_count,
  input logic [15:0] result_in,
  input logic [15:0] config_word,
  input logic serial_data_out,
  input logic serial_data_out_oe_b,
  input logic busy_or_second_data_out,
  input logic busy_or_second_data_out_oe_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Pin may rise a full cycle before the first sample: one cycle off
  localparam logic [7:0] LIM [8] = '{8'h27, 8'h52, 8'h7C, 8'hA6,
    8'h2A, 8'h54, 8'h7E, 8'hA8};
  wire busy = busy_or_second_data_out;
  wire off = chip_select_b || power_down;
  logic [7:0] age;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) age <= 8'h00;
    else if ($rose(convert_start)) age <= 8'h00;
    else if (age != 8'hFF) age <= age + 8'h01;
  sequence s_start;
    busy_enable && $rose(convert_start) && !busy;
  endsequence
  sequence s_end;
    busy_enable && conversion_done;
  endsequence
  a_busy_rise:
    assert property (s_start |-> ##[1:13] busy)
    else $error("busy late");
  a_conv_time:
    assert property (conversion_done |->
      age <= LIM[{conversion_speed_select, channel_count}])
    else $error("conversion slow");
  a_busy_release:
    assert property (s_end |-> ##[0:1] !busy)
    else $error("busy stuck");
  a_busy_hold:
    assert property ($fell(busy) && busy_enable |->
      conversion_done || $past(conversion_done))
    else $error("busy early");
  a_ready_follow:
    assert property (conversion_done |=> result_ready)
    else $error("no ready");
  a_out_hiz:
    assert property (off [*4] |-> serial_data_out_oe_b)
    else $error("output driven");
  a_out_drive:
    assert property (!off [*4] |-> !serial_data_out_oe_b)
    else $error("output off");
  a_bit_hold:
    assert property (serial_clock [*3] |-> $stable(serial_data_out))
    else $error("bit moved");
  a_busy_oe:
    assert property ($rose(busy_enable) |-> ##[0:2]
      !busy_or_second_data_out_oe_b)
    else $error("busy pin off");
endmodule

// [sim/sac_host.sv]
`timescale 1ns/1ps
module sac_host (
  input logic clk,
  input logic serial_data_out,
  input logic serial_data_out_oe_b,
  output logic convert_start,
  output logic chip_select_b,
  output logic serial_clock,
  output logic serial_data_in
);
  initial {convert_start, chip_select_b, serial_clock, serial_data_in} = 4'h4;
  // Bench spaces starts within both limits
  // Tied select follows the start pulse, as if wired to it
  task conv(input logic tie);
    @(posedge clk) #1 convert_start = 1;
    if (tie) chip_select_b = 1;
    repeat (2) @(posedge clk);
    #1 convert_start = 0;
    if (tie) chip_select_b = 0;
  endtask
  // Link clock runs only in frames, offset from the system clock
  task frame(input logic [15:0] cfg, input logic hold,
    output logic [31:0] rd);
    #13 chip_select_b = 0;
    for (int i = 31; i >= 0; i--) begin
      #160 serial_clock = 1;
      serial_data_in = (i > 15) ? cfg[i-16] : ~serial_data_in;
      // A released pin reads back inverted, so a missed drive shows
      #160 rd[i] = serial_data_out ^ serial_data_out_oe_b;
      serial_clock = 0;
    end
    #160 chip_select_b = hold;
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst_b = 0, power_down = 0, busy_enable = 1;
  logic conversion_speed_select = 1, result_valid = 1;
  logic [1:0] channel_count = 0;
  logic [15:0] result_in = 0, config_word, cur_cfg = 16'hFFFF;
  logic convert_start, chip_select_b, serial_clock, serial_data_in;
  logic result_ready, serial_data_out, serial_data_out_oe_b;
  logic busy_or_second_data_out, busy_or_second_data_out_oe_b;
  logic conversion_done;
  logic [15:0] q [8];
  int n_fail = 0, check_count = 0;
  always #20 clk = ~clk;
  sac_host h (
    .clk(clk),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe_b(serial_data_out_oe_b),
    .convert_start(convert_start),
    .chip_select_b(chip_select_b),
    .serial_clock(serial_clock),
    .serial_data_in(serial_data_in)
  );
  sac_top i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .convert_start(convert_start),
    .chip_select_b(chip_select_b),
    .serial_clock(serial_clock),
    .serial_data_in(serial_data_in),
    .power_down(power_down),
    .conversion_speed_select(conversion_speed_select),
    .busy_enable(busy_enable),
    .channel_count(channel_count),
    .result_in(result_in),
    .result_valid(result_valid),
    .result_ready(result_ready),
    .config_word(config_word),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe_b(serial_data_out_oe_b),
    .busy_or_second_data_out(busy_or_second_data_out),
    .busy_or_second_data_out_oe_b(busy_or_second_data_out_oe_b),
    .conversion_done(conversion_done)
  );
  function logic [31:0] exp_frame(logic [15:0] r, c);
    return {r, c};
  endfunction
  task check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wait_done();
    int k;
    for (k = 0; k < 300 && conversion_done !== 1'b1; k++) @(negedge clk);
    if (k == 300) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task run(input logic [2:0] m, input logic hold);
    logic [15:0] res, cfg;
    logic [31:0] rd;
    @(posedge clk) #1 {conversion_speed_select, channel_count} = m;
    {res, cfg} = $urandom;
    if (m == 3'h7) {res, cfg} = 32'h8000_7FFF;
    result_in = res;
    h.conv(m == 3'h6);
    wait_done();
    repeat (3) @(negedge clk);
    check(busy_or_second_data_out, 1'b0);
    h.frame(cfg, hold, rd);
    check(rd, exp_frame(res, cur_cfg));
    @(negedge clk) check(config_word, cfg);
    cur_cfg = cfg;
    $display("run %0d done", m);
  endtask
  initial begin
    logic [31:0] rd;
    logic [15:0] c;
    void'($urandom(82));
    repeat (4) @(posedge clk);
    #1 rst_b = 1;
    check(config_word, 16'hFFFF);
    check(serial_data_out_oe_b, 1'b1);
    repeat (3) @(posedge clk);
    for (int m = 0; m < 8; m++) begin
      run(m[2:0], m == 5);
      if (m == 4) begin
        @(posedge clk) #1 power_down = 1;
        repeat (4) @(negedge clk);
        check(serial_data_out_oe_b, 1'b1);
        @(posedge clk) #1 power_down = 0;
        repeat (4) @(negedge clk);
        check(serial_data_out_oe_b, 1'b0);
      end
    end
    repeat (4) run(3'($urandom), 1'b0);
    @(posedge clk) #1 busy_enable = 0;
    repeat (2) @(negedge clk);
    check(busy_or_second_data_out_oe_b, 1'b1);
    for (int i = 0; i < 8; i++) begin
      q[i] = 16'($urandom);
      @(posedge clk) #1 result_in = q[i];
      h.conv(1'b0);
      wait_done();
      repeat (60) @(posedge clk);
    end
    for (int i = 0; i < 8; i++) begin
      c = 16'($urandom);
      h.frame(c, 1'b0, rd);
      check(rd, exp_frame(q[i], cur_cfg));
    end
    cur_cfg = c;
    $display("fill done");
    @(posedge clk) #1 busy_enable = 1;
    run(3'h0, 1'b0);
    report_and_stop();
  end
endmodule
bind sac_top sac_monitor i_mon (
  .clk(clk),
  .rst_b(rst_b),
  .convert_start(convert_start),
  .chip_select_b(chip_select_b),
  .serial_clock(serial_clock),
  .serial_data_in(serial_data_in),
  .power_down(power_down),
  .conversion_speed_select(conversion_speed_select),
  .busy_enable(busy_enable),
  .result_valid(result_valid),
  .result_ready(result_ready),
  .conversion_done(conversion_done),
  .channel_count(channel_count),
  .result_in(result_in),
  .config_word(config_word),
  .serial_data_out(serial_data_out),
  .serial_data_out_oe_b(serial_data_out_oe_b),
  .busy_or_second_data_out(busy_or_second_data_out),
  .busy_or_second_data_out_oe_b(busy_or_second_data_out_oe_b)
);
